// [src/ascn_pkg.sv]
// package: register map, layouts and reset values for the analog select / change notify block
package ascn_pkg;
  localparam int unsigned ASCN_NPORTS = 6;
  localparam int unsigned ASCN_NCN    = 6;

  // port order in every per-port array: a, b, c, d, e, g
  localparam logic [15:0] ASCN_ANS_IMPL [ASCN_NPORTS] = '{
    16'h06C0, 16'hFFFF, 16'h0010, 16'h0CC0, 16'h02F0, 16'h03C0};
  localparam logic [15:0] ASCN_ANS_RST [ASCN_NPORTS] = '{
    16'h06C0, 16'hFFFF, 16'h0010, 16'h0CC0, 16'h02F0, 16'h03C0};
  localparam logic [15:0] ASCN_DIR_RST   = 16'hFFFF;
  localparam logic [15:0] ASCN_CNEN_RST  = 16'h0000;
  localparam logic [15:0] ASCN_PULL_RST  = 16'h0000;
  localparam logic [15:0] ASCN_CN_IMPL [ASCN_NCN] = '{
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0003};

  // word index groups; byte address = index * 4
  localparam logic [7:0] ASCN_IDX_ANS    = 8'h00;
  localparam logic [7:0] ASCN_IDX_DIR    = 8'h08;
  localparam logic [7:0] ASCN_IDX_PORT   = 8'h10;
  localparam logic [7:0] ASCN_IDX_CNEN   = 8'h18;
  localparam logic [7:0] ASCN_IDX_CNPU   = 8'h20;
  localparam logic [7:0] ASCN_IDX_CNPD   = 8'h28;
  localparam logic [7:0] ASCN_IDX_STATUS = 8'h30;
  localparam int unsigned ASCN_STAT_FLAG = 0;
endpackage

// [src/ascn_cn_if.sv]
// interface: change detect request and flag between main block and detector
`timescale 1ns/1ps
`default_nettype none
interface ascn_cn_if;
  logic [15:0] pins   [6];
  logic [15:0] enable [6];
  logic        clear;
  logic        flag;
  modport ctrl (output pins, output enable, output clear, input flag);
  modport det  (input pins, input enable, input clear, output flag);
endinterface
`default_nettype wire

// [src/ascn_cn_detect.sv]
// module: change-of-state detector over all notify inputs, one sticky flag
`timescale 1ns/1ps
`default_nettype none
module ascn_cn_detect
  import ascn_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  ascn_cn_if.det    cn
);
  typedef struct packed {
    logic [ASCN_NCN-1:0][15:0] last;
    logic                      flag;
  } ascn_det_type;

  ascn_det_type s_q;
  ascn_det_type s_d;
  logic [ASCN_NCN-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < ASCN_NCN; g++) begin : gen_cmp
      assign hit[g] = |((cn.pins[g] ^ s_q.last[g]) & cn.enable[g] & ASCN_CN_IMPL[g]);
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < ASCN_NCN; i++) begin
      s_d.last[i] = cn.pins[i];
    end
    // set wins over a clear in the same cycle
    if (|hit) begin
      s_d.flag = 1'b1;
    end else if (cn.clear) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cn.flag = s_q.flag;
endmodule
`default_nettype wire

// [src/ascn_top.sv]
// top: analog select, direction, port read gating and change notify controls
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ascn_top
  import ascn_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [95:0] pin_in_i,
  input  wire logic [95:0] cn_pin_i,
  output logic      [95:0] analog_sel_o,
  output logic      [95:0] dir_in_o,
  output logic      [95:0] pullup_en_o,
  output logic      [95:0] pulldown_en_o,
  output logic             cn_irq_o
);
  typedef struct packed {
    logic [ASCN_NPORTS-1:0][15:0] ans;
    logic [ASCN_NPORTS-1:0][15:0] dir;
    logic [ASCN_NPORTS-1:0][15:0] pinv;
    logic [ASCN_NCN-1:0][15:0]    cnen;
    logic [ASCN_NCN-1:0][15:0]    cnpu;
    logic [ASCN_NCN-1:0][15:0]    cnpd;
    logic [31:0]                  rdat;
    logic                         ack;
    logic                         clr;
    logic                         irq;
  } ascn_top_type;

  ascn_top_type s_q;
  ascn_top_type s_d;
  ascn_cn_if    cn_bus ();

  logic [7:0]  idx;
  logic [2:0]  sub;
  logic [7:0]  grp;
  logic        req;
  logic        wr;
  logic [15:0] wmask;
  logic [15:0] gated [ASCN_NPORTS];

  assign idx   = wb_adr_i[9:2];
  assign sub   = idx[2:0];
  assign grp   = {idx[7:3], 3'b000};
  assign req   = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr    = req & wb_we_i;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  genvar g;
  generate
    for (g = 0; g < ASCN_NPORTS; g++) begin : gen_port
      // analog pins read low regardless of the pad level
      assign gated[g] = pin_in_i[g*16 +: 16] & ~s_q.ans[g] & ASCN_ANS_IMPL[g]
                      | pin_in_i[g*16 +: 16] & ~ASCN_ANS_IMPL[g];
      assign cn_bus.pins[g]   = cn_pin_i[g*16 +: 16];
      assign cn_bus.enable[g] = s_q.cnen[g];
      assign analog_sel_o[g*16 +: 16]  = s_q.ans[g];
      assign dir_in_o[g*16 +: 16]      = s_q.dir[g];
      assign pullup_en_o[g*16 +: 16]   = s_q.cnpu[g];
      assign pulldown_en_o[g*16 +: 16] = s_q.cnpd[g];
    end
  endgenerate

  assign cn_bus.clear = s_q.clr;

  ascn_cn_detect u_det (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cn    (cn_bus)
  );

  always_comb begin
    s_d      = s_q;
    s_d.ack  = req;
    s_d.clr  = 1'b0;
    s_d.irq  = cn_bus.flag;
    s_d.rdat = 32'h0000_0000;
    // registered sample gives the one-cycle settle window after a direction change
    for (int i = 0; i < ASCN_NPORTS; i++) begin
      s_d.pinv[i] = gated[i];
    end
    if (req && sub < 3'(ASCN_NPORTS)) begin
      if (grp == ASCN_IDX_ANS) begin
        s_d.rdat = {16'h0000, s_q.ans[sub]};
        if (wr) begin
          // only implemented positions take the write
          s_d.ans[sub] = (s_q.ans[sub] & ~(wmask & ASCN_ANS_IMPL[sub]))
                       | (wb_dat_i[15:0] & wmask & ASCN_ANS_IMPL[sub]);
        end
      end else if (grp == ASCN_IDX_DIR) begin
        s_d.rdat = {16'h0000, s_q.dir[sub]};
        if (wr) begin
          s_d.dir[sub] = (s_q.dir[sub] & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
      end else if (grp == ASCN_IDX_PORT) begin
        s_d.rdat = {16'h0000, s_q.pinv[sub]};
      end else if (grp == ASCN_IDX_CNEN) begin
        s_d.rdat = {16'h0000, s_q.cnen[sub]};
        if (wr) begin
          s_d.cnen[sub] = (s_q.cnen[sub] & ~(wmask & ASCN_CN_IMPL[sub]))
                        | (wb_dat_i[15:0] & wmask & ASCN_CN_IMPL[sub]);
        end
      end else if (grp == ASCN_IDX_CNPU) begin
        s_d.rdat = {16'h0000, s_q.cnpu[sub]};
        if (wr) begin
          s_d.cnpu[sub] = (s_q.cnpu[sub] & ~(wmask & ASCN_CN_IMPL[sub]))
                        | (wb_dat_i[15:0] & wmask & ASCN_CN_IMPL[sub]);
        end
      end else if (grp == ASCN_IDX_CNPD) begin
        s_d.rdat = {16'h0000, s_q.cnpd[sub]};
        if (wr) begin
          s_d.cnpd[sub] = (s_q.cnpd[sub] & ~(wmask & ASCN_CN_IMPL[sub]))
                        | (wb_dat_i[15:0] & wmask & ASCN_CN_IMPL[sub]);
        end
      end else if (idx == ASCN_IDX_STATUS) begin
        s_d.rdat = {31'h0000_0000, cn_bus.flag};
        // write 1 to clear; a coincident change keeps the flag set
        if (wr && wb_sel_i[0] && wb_dat_i[ASCN_STAT_FLAG]) begin
          s_d.clr = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ASCN_NPORTS; i++) begin
        s_q.ans[i]  <= ASCN_ANS_RST[i];
        s_q.dir[i]  <= ASCN_DIR_RST;
        s_q.pinv[i] <= 16'h0000;
        s_q.cnen[i] <= ASCN_CNEN_RST;
        s_q.cnpu[i] <= ASCN_PULL_RST;
        s_q.cnpd[i] <= ASCN_PULL_RST;
      end
      s_q.rdat <= 32'h0000_0000;
      s_q.ack  <= 1'b0;
      s_q.clr  <= 1'b0;
      s_q.irq  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign cn_irq_o = s_q.irq;
endmodule
`default_nettype wire

// [sim/ascn_top_assertions.sv]
// checker: port-level properties of the analog select / change notify block
`timescale 1ns/1ps
`default_nettype none
module ascn_checker (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_we_i, wb_ack_o, cn_irq_o,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [95:0] cn_pin_i, analog_sel_o, dir_in_o, pullup_en_o, pulldown_en_o
);
  localparam logic [95:0] IMPL = 96'h03C0_02F0_0CC0_0010_FFFF_06C0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_sel_impl: assert property ((analog_sel_o & ~IMPL) == '0)
    else $error("select bit outside map");
  a_sel_reset: assert property ($past(rst_i) |-> analog_sel_o == IMPL)
    else $error("select reset value");
  a_dir_reset: assert property ($past(rst_i) |-> &dir_in_o)
    else $error("direction reset value");
  a_pull_reset: assert property ($past(rst_i) |-> (pullup_en_o | pulldown_en_o) == '0)
    else $error("pull reset value");
  a_read_gate: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:5] == 5'b00010
    && wb_adr_i[4:2] < 3'h6 |-> (wb_dat_o[15:0] & analog_sel_o[wb_adr_i[4:2]*16 +: 16]) == '0)
    else $error("analog pin read high");
  a_irq_cause: assert property ($rose(cn_irq_o) |-> $past(cn_pin_i, 2) != $past(cn_pin_i, 3))
    else $error("irq without change");
  a_irq_sticky: assert property ((cn_irq_o && !wb_cyc_i) [*8] |=> cn_irq_o)
    else $error("irq dropped uncleared");
endmodule
bind ascn_top ascn_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .cn_irq_o(cn_irq_o), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .cn_pin_i(cn_pin_i), .analog_sel_o(analog_sel_o), .dir_in_o(dir_in_o),
  .pullup_en_o(pullup_en_o), .pulldown_en_o(pulldown_en_o));
`default_nettype wire

// [sim/ascn_top_bench.sv]
// bench: register map, pin read gating and change notify
`timescale 1ns/1ps
`default_nettype none
module ascn_top_bench;
  import ascn_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [9:0]  adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [95:0] pins = '0, cn = '0, sel_o, dir_o, pu_o, pd_o;
  logic [15:0] q, r;
  int          fail_count = 0, check_count = 0, seed = 70845, k;
  ascn_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_in_i(pins), .cn_pin_i(cn), .analog_sel_o(sel_o), .dir_in_o(dir_o),
    .pullup_en_o(pu_o), .pulldown_en_o(pd_o), .cn_irq_o(irq));
  initial forever #5 clk_i = ~clk_i;
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask
  function automatic logic [15:0] pin_exp(input logic [15:0] p, input logic [15:0] s);
    return p & ~s;
  endfunction
  // holds the request until ack is sampled, then releases for one cycle
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int p = 0; p < 6; p++) begin
      bus(1'b0, ASCN_IDX_ANS + 8'(p), '0);
      chk_val(q, ASCN_ANS_RST[p]);
      bus(1'b0, ASCN_IDX_DIR + 8'(p), '0);
      chk_val(q, 16'hFFFF);
      r = 16'($random(seed));
      pins[p*16 +: 16] <= 16'($random(seed));
      bus(1'b1, ASCN_IDX_ANS + 8'(p), r);
      bus(1'b0, ASCN_IDX_ANS + 8'(p), '0);
      chk_val(q, r & ASCN_ANS_IMPL[p]);
      bus(1'b0, ASCN_IDX_PORT + 8'(p), '0);
      chk_val(q, pin_exp(pins[p*16 +: 16], r & ASCN_ANS_IMPL[p]));
    end
    bus(1'b0, 8'h3F, '0);
    chk_val(q, 16'h0000);
    r = 16'($random(seed));
    bus(1'b1, ASCN_IDX_CNPU, r);
    chk_val(pu_o[15:0], r);
    bus(1'b1, ASCN_IDX_CNPD + 8'h05, r);
    chk_val(pd_o[95:80], r & ASCN_CN_IMPL[5]);
    // first and last notify input; other inputs get random toggles while disabled
    for (int j = 0; j < 2; j++) begin
      k = j * 81;
      bus(1'b1, ASCN_IDX_CNEN + 8'(k / 16), 16'(1 << (k % 16)));
      cn <= cn ^ ({$random(seed), $random(seed), $random(seed)} & ~(96'h1 << k));
      repeat (4) @(posedge clk_i);
      chk_bit(irq, 1'b0);
      cn[k] <= ~cn[k];
      repeat (4) @(posedge clk_i);
      chk_bit(irq, 1'b1);
      repeat (10) @(posedge clk_i);
      bus(1'b0, ASCN_IDX_STATUS, '0);
      chk_bit(q[ASCN_STAT_FLAG], 1'b1);
      bus(1'b1, ASCN_IDX_STATUS, 16'h0001);
      bus(1'b1, ASCN_IDX_CNEN + 8'(k / 16), '0);
      repeat (4) @(posedge clk_i);
      chk_bit(irq, 1'b0);
    end
    // port e as digital input, then digital output, then back to analog use
    pins[79:64] <= 16'hFFFF;
    bus(1'b1, ASCN_IDX_ANS + 8'h04, 16'h0000);
    bus(1'b1, ASCN_IDX_DIR + 8'h04, 16'hFFFF);
    // one spare cycle between the direction write and the port read
    @(posedge clk_i);
    bus(1'b0, ASCN_IDX_PORT + 8'h04, '0);
    chk_val(q, 16'hFFFF);
    chk_val(dir_o[79:64], 16'hFFFF);
    bus(1'b1, ASCN_IDX_CNPU + 8'h04, '0);
    bus(1'b1, ASCN_IDX_DIR + 8'h04, 16'h0000);
    chk_val(dir_o[79:64] | pu_o[79:64], 16'h0000);
    bus(1'b1, ASCN_IDX_ANS + 8'h04, 16'hFFFF);
    bus(1'b1, ASCN_IDX_DIR + 8'h04, 16'hFFFF);
    chk_val(sel_o[79:64], ASCN_ANS_IMPL[4]);
    bus(1'b0, ASCN_IDX_PORT + 8'h04, '0);
    chk_val(q, 16'hFFFF & ~ASCN_ANS_IMPL[4]);
    stop_test;
  end
endmodule
`default_nettype wire
